/* design/rpmsu_pkg.sv */
// constants and types shared by the register pointer and memory segment unit
package rpmsu_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] RPMSU_OFS_LBP  = 8'h00;
  localparam logic [7:0] RPMSU_OFS_HBP  = 8'h04;
  localparam logic [7:0] RPMSU_OFS_PPR  = 8'h08;
  localparam logic [7:0] RPMSU_OFS_CSR  = 8'h0C;
  localparam logic [7:0] RPMSU_OFS_ISR  = 8'h10;
  localparam logic [7:0] RPMSU_OFS_DMAS = 8'h14;
  localparam logic [7:0] RPMSU_OFS_DPR  = 8'h18;
  localparam logic [7:0] RPMSU_OFS_CTRL = 8'h1C;
  localparam logic [7:0] RPMSU_OFS_STAT = 8'h20;
  // control and status bit positions
  localparam int RPMSU_CTRL_SPLIT = 0;
  localparam int RPMSU_CTRL_EXT   = 1;
  localparam int RPMSU_CTRL_DPS   = 2;
  localparam int RPMSU_STAT_ISR   = 0;
  localparam int RPMSU_STAT_BUSY  = 1;
  // reset values
  localparam logic [4:0]  RPMSU_RST_BP  = 5'h00;
  localparam logic [5:0]  RPMSU_RST_SEG = 6'h00;
  localparam logic [31:0] RPMSU_RST_DPR = 32'h0000_0000;
  // register file and data page geometry
  localparam logic [3:0] RPMSU_PAGED_GROUP = 4'hF;
  localparam int RPMSU_PAGE_SEL_LSB = 14;
  // far branch overhead over a near branch, in cycles
  localparam int RPMSU_FAR_EXTRA_MIN = 2;
  localparam int RPMSU_FAR_EXTRA_MAX = 4;

  typedef enum logic [1:0] {
    RPMSU_FETCH,
    RPMSU_DATA,
    RPMSU_DMA,
    RPMSU_VECTOR
  } rpmsu_kind_t;

  typedef enum logic [2:0] {
    RPMSU_S_IDLE,
    RPMSU_S_PUSH_PC,
    RPMSU_S_PUSH_SEG,
    RPMSU_S_PUSH_FLAGS,
    RPMSU_S_LOAD
  } rpmsu_state_t;

  // a segment prefix above a 16-bit offset gives the physical address
  function automatic logic [21:0] rpmsu_seg_addr(input logic [5:0] seg,
                                                 input logic [15:0] ofs);
    rpmsu_seg_addr = {seg, ofs};
  endfunction
endpackage

/* design/rpmsu_map_if.sv */
// links the unit's core to its two address mapping blocks
`timescale 1ns/1ps
interface rpmsu_map_if;
  import rpmsu_pkg::*;
  logic        split;
  logic [4:0]  lbp;
  logic [4:0]  hbp;
  logic [5:0]  peripheral_page_pointer;
  logic [3:0]  wreg_idx;
  logic [7:0]  reg_addr;
  logic [5:0]  reg_page;
  logic        reg_paged;
  rpmsu_kind_t kind;
  logic [15:0] laddr;
  logic [5:0]  code_segment_reg;
  logic [5:0]  interrupt_segment_reg;
  logic [5:0]  dma_segment_reg;
  logic [31:0] dpr;
  logic        dps;
  logic        use_isr;
  logic [21:0] phys;
  modport ctl (output split, lbp, hbp, peripheral_page_pointer, wreg_idx, kind, laddr, code_segment_reg, interrupt_segment_reg, dma_segment_reg, dpr,
               dps, use_isr, input reg_addr, reg_page, reg_paged, phys);
  modport rp  (input split, lbp, hbp, peripheral_page_pointer, wreg_idx, output reg_addr, reg_page, reg_paged);
  modport seg (input kind, laddr, code_segment_reg, interrupt_segment_reg, dma_segment_reg, dpr, dps, use_isr, output phys);
endinterface

/* design/rpmsu_reg_map.sv */
// working register number to absolute register file address
`timescale 1ns/1ps
module rpmsu_reg_map
  import rpmsu_pkg::*;
(
  rpmsu_map_if.rp m
);
  logic [7:0] abs_addr;

  always_comb
  begin
    if (m.split)
    begin
      if (m.wreg_idx[3])
        abs_addr = {m.hbp, m.wreg_idx[2:0]};
      else
        abs_addr = {m.lbp, m.wreg_idx[2:0]};
    end
    else
      abs_addr = {m.lbp[4:1], m.wreg_idx};
  end

  assign m.reg_addr  = abs_addr;
  assign m.reg_paged = (abs_addr[7:4] == RPMSU_PAGED_GROUP);
  assign m.reg_page  = m.peripheral_page_pointer;
endmodule

/* design/rpmsu_seg_map.sv */
// 16-bit logical address to 22-bit physical address
`timescale 1ns/1ps
module rpmsu_seg_map
  import rpmsu_pkg::*;
(
  rpmsu_map_if.seg m
);
  logic [1:0] dsel;
  logic [7:0] dpage;

  assign dsel  = m.laddr[15:RPMSU_PAGE_SEL_LSB];
  assign dpage = m.dpr[{dsel, 3'b000} +: 8];

  always_comb
  begin
    case (m.kind)
      RPMSU_FETCH:
        m.phys = rpmsu_seg_addr(m.use_isr ? m.interrupt_segment_reg : m.code_segment_reg, m.laddr);
      RPMSU_DMA:
        m.phys = rpmsu_seg_addr(m.dps ? m.dma_segment_reg : m.interrupt_segment_reg, m.laddr);
      RPMSU_VECTOR:
        m.phys = rpmsu_seg_addr(m.interrupt_segment_reg, m.laddr);
      RPMSU_DATA:
        m.phys = {dpage, m.laddr[RPMSU_PAGE_SEL_LSB-1:0]};
      default:
        m.phys = '0;
    endcase
  end
endmodule

/* design/rpmsu_top.sv */
// register pointer and memory segment unit with its register bus slave
`timescale 1ns/1ps
module rpmsu_top
  import rpmsu_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // working register translation
  input  wire logic [3:0]  wreg_idx,
  output logic      [7:0]  reg_addr,
  output logic      [5:0]  reg_page,
  output logic             reg_paged,
  // memory address extension
  input  wire logic        mem_req,
  input  wire rpmsu_kind_t mem_kind,
  input  wire logic [15:0] mem_laddr,
  output logic      [21:0] mem_phys,
  output logic             mem_valid,
  // far branch and interrupt sequencing
  input  wire logic        far_call,
  input  wire logic        far_ret,
  input  wire logic        irq_enter,
  input  wire logic        irq_ret,
  input  wire logic [5:0]  tgt_seg,
  input  wire logic [15:0] tgt_pc,
  input  wire logic [15:0] cur_pc,
  input  wire logic [7:0]  cur_flags,
  input  wire logic [5:0]  pop_seg,
  output logic             stack_push,
  output logic      [15:0] stack_data,
  output logic             pc_load,
  output logic      [15:0] pc_value,
  output logic             busy
);
  typedef struct packed {
    logic [4:0]   lbp;
    logic [4:0]   hbp;
    logic [5:0]   peripheral_page_pointer;
    logic [5:0]   code_segment_reg;
    logic [5:0]   interrupt_segment_reg;
    logic [5:0]   dma_segment_reg;
    logic [31:0]  dpr;
    logic         split;
    logic         ext;
    logic         dps;
    logic         in_isr;
    rpmsu_state_t state;
    logic         is_irq;
    logic [15:0]  pc_save;
    logic [7:0]   flags_save;
    logic [5:0]   seg_new;
    logic [15:0]  pc_new;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [7:0]   reg_addr;
    logic [5:0]   reg_page;
    logic         reg_paged;
    logic [21:0]  mem_phys;
    logic         mem_valid;
    logic         stack_push;
    logic [15:0]  stack_data;
    logic         pc_load;
    logic [15:0]  pc_value;
    logic         busy;
  } rpmsu_st_t;

  rpmsu_st_t   st;
  rpmsu_st_t   next_st;
  rpmsu_map_if map ();

  logic        acc;
  logic        wr_now;
  logic [31:0] rd_val;
  logic        rd_ok;

  // offsets that answer on the bus; anything else reports an error
  function automatic logic ofs_mapped(input logic [7:0] a);
    case (a)
      RPMSU_OFS_LBP,
      RPMSU_OFS_HBP,
      RPMSU_OFS_PPR,
      RPMSU_OFS_CSR,
      RPMSU_OFS_ISR,
      RPMSU_OFS_DMAS,
      RPMSU_OFS_DPR,
      RPMSU_OFS_CTRL,
      RPMSU_OFS_STAT: ofs_mapped = 1'b1;
      default:        ofs_mapped = 1'b0;
    endcase
  endfunction

  // stack words are 16 bits wide; narrow values sit in the low bits
  function automatic logic [15:0] stack_word(input logic [7:0] v);
    stack_word = {8'h00, v};
  endfunction

  // mapping blocks see the current settings
  assign map.split    = st.split;
  assign map.lbp      = st.lbp;
  assign map.hbp      = st.hbp;
  assign map.peripheral_page_pointer      = st.peripheral_page_pointer;
  assign map.wreg_idx = wreg_idx;
  assign map.kind     = mem_kind;
  assign map.laddr    = mem_laddr;
  assign map.code_segment_reg      = st.code_segment_reg;
  assign map.interrupt_segment_reg      = st.interrupt_segment_reg;
  assign map.dma_segment_reg    = st.dma_segment_reg;
  assign map.dpr      = st.dpr;
  assign map.dps      = st.dps;
  assign map.use_isr  = st.in_isr & ~st.ext;

  rpmsu_reg_map u_reg_map (
    .m (map)
  );

  rpmsu_seg_map u_seg_map (
    .m (map)
  );

  // access phase; pready comes one cycle into it
  // the pready flop also keeps a held access phase from completing in two cycles in a row
  assign acc    = psel & penable;
  assign wr_now = acc & st.pready & pwrite & ofs_mapped(paddr);

  // register read decode
  always_comb
  begin
    rd_ok  = ofs_mapped(paddr);
    rd_val = 32'h0000_0000;
    case (paddr)
      RPMSU_OFS_LBP:  rd_val[4:0] = st.lbp;
      RPMSU_OFS_HBP:  rd_val[4:0] = st.hbp;
      RPMSU_OFS_PPR:  rd_val[5:0] = st.peripheral_page_pointer;
      RPMSU_OFS_CSR:  rd_val[5:0] = st.code_segment_reg;
      RPMSU_OFS_ISR:  rd_val[5:0] = st.interrupt_segment_reg;
      RPMSU_OFS_DMAS: rd_val[5:0] = st.dma_segment_reg;
      RPMSU_OFS_DPR:  rd_val      = st.dpr;
      RPMSU_OFS_CTRL:
      begin
        rd_val[RPMSU_CTRL_SPLIT] = st.split;
        rd_val[RPMSU_CTRL_EXT]   = st.ext;
        rd_val[RPMSU_CTRL_DPS]   = st.dps;
      end
      RPMSU_OFS_STAT:
      begin
        rd_val[RPMSU_STAT_ISR]  = st.in_isr;
        rd_val[RPMSU_STAT_BUSY] = st.busy;
      end
      default:        rd_val      = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_st = st;

    // bus answer
    next_st.pready  = acc & ~st.pready;
    next_st.pslverr = acc & ~st.pready & ~rd_ok;
    if (acc & ~st.pready & ~pwrite & rd_ok)
      next_st.prdata = rd_val;
    else if (acc & ~st.pready)
      next_st.prdata = 32'h0000_0000;

    // register writes take effect at the completing edge
    if (wr_now)
    begin
      case (paddr)
        RPMSU_OFS_LBP:  next_st.lbp   = pwdata[4:0];
        RPMSU_OFS_HBP:  next_st.hbp   = pwdata[4:0];
        RPMSU_OFS_PPR:  next_st.peripheral_page_pointer   = pwdata[5:0];
        RPMSU_OFS_CSR:  next_st.code_segment_reg   = pwdata[5:0];
        RPMSU_OFS_ISR:  next_st.interrupt_segment_reg   = pwdata[5:0];
        RPMSU_OFS_DMAS: next_st.dma_segment_reg = pwdata[5:0];
        RPMSU_OFS_DPR:  next_st.dpr   = pwdata;
        RPMSU_OFS_CTRL:
        begin
          next_st.split = pwdata[RPMSU_CTRL_SPLIT];
          next_st.ext   = pwdata[RPMSU_CTRL_EXT];
          next_st.dps   = pwdata[RPMSU_CTRL_DPS];
        end
        default:
        begin
        end
      endcase
    end

    // working register translation, registered
    next_st.reg_addr  = map.reg_addr;
    next_st.reg_page  = map.reg_page;
    next_st.reg_paged = map.reg_paged;

    // memory address extension, registered
    // mem_phys keeps its last value between requests
    next_st.mem_valid = mem_req;
    if (mem_req)
      next_st.mem_phys = map.phys;

    // sequencer pulses last one cycle
    // requests that arrive while busy are dropped; the core waits for busy low
    next_st.stack_push = 1'b0;
    next_st.pc_load    = 1'b0;

    case (st.state)
      RPMSU_S_IDLE:
      begin
        if (far_call)
        begin
          next_st.is_irq  = 1'b0;
          next_st.pc_save = cur_pc;
          next_st.seg_new = tgt_seg;
          next_st.pc_new  = tgt_pc;
          next_st.state   = RPMSU_S_PUSH_PC;
        end
        else if (irq_enter)
        begin
          next_st.is_irq     = 1'b1;
          next_st.pc_save    = cur_pc;
          next_st.flags_save = cur_flags;
          next_st.seg_new    = st.interrupt_segment_reg;
          next_st.pc_new     = tgt_pc;
          next_st.in_isr     = 1'b1;
          next_st.state      = RPMSU_S_PUSH_PC;
        end
        else if (far_ret)
          next_st.code_segment_reg = pop_seg;
        else if (irq_ret)
        begin
          next_st.in_isr = 1'b0;
          // compatible mode never saved the segment, so it stays
          if (st.ext)
            next_st.code_segment_reg = pop_seg;
        end
      end
      RPMSU_S_PUSH_PC:
      begin
        next_st.stack_push = 1'b1;
        next_st.stack_data = st.pc_save;
        if (st.is_irq & ~st.ext)
          next_st.state = RPMSU_S_PUSH_FLAGS;
        else
          next_st.state = RPMSU_S_PUSH_SEG;
      end
      RPMSU_S_PUSH_SEG:
      begin
        next_st.stack_push = 1'b1;
        next_st.stack_data = stack_word({2'b00, st.code_segment_reg});
        if (st.is_irq)
          next_st.state = RPMSU_S_PUSH_FLAGS;
        else
          next_st.state = RPMSU_S_LOAD;
      end
      RPMSU_S_PUSH_FLAGS:
      begin
        next_st.stack_push = 1'b1;
        next_st.stack_data = stack_word(st.flags_save);
        next_st.state      = RPMSU_S_LOAD;
      end
      RPMSU_S_LOAD:
      begin
        next_st.pc_load  = 1'b1;
        next_st.pc_value = st.pc_new;
        // compatible-mode interrupts run on the interrupt segment instead
        if (~st.is_irq | st.ext)
          next_st.code_segment_reg = st.seg_new;
        next_st.state = RPMSU_S_IDLE;
      end
      default:
        next_st.state = RPMSU_S_IDLE;
    endcase

    next_st.busy = (next_st.state != RPMSU_S_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // mapped outputs clear as well, so nothing stale shows after reset
      st        <= '0;
      st.lbp    <= RPMSU_RST_BP;
      st.hbp    <= RPMSU_RST_BP;
      st.peripheral_page_pointer    <= RPMSU_RST_SEG;
      st.code_segment_reg    <= RPMSU_RST_SEG;
      st.interrupt_segment_reg    <= RPMSU_RST_SEG;
      st.dma_segment_reg  <= RPMSU_RST_SEG;
      st.dpr    <= RPMSU_RST_DPR;
      st.state  <= RPMSU_S_IDLE;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state flops
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign reg_addr   = st.reg_addr;
  assign reg_page   = st.reg_page;
  assign reg_paged  = st.reg_paged;
  assign mem_phys   = st.mem_phys;
  assign mem_valid  = st.mem_valid;
  assign stack_push = st.stack_push;
  assign stack_data = st.stack_data;
  assign pc_load    = st.pc_load;
  assign pc_value   = st.pc_value;
  assign busy       = st.busy;
endmodule

/* verif/rpmsu_core_model.sv */
// core-side stack model: records pushed words and hands back the saved segment
`timescale 1ns/1ps
module rpmsu_core_model
(
  // clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // stack traffic from the unit
  input  logic        stack_push,
  input  logic        busy,
  input  logic [15:0] stack_data,
  output logic [5:0]  pop_seg
);
  logic [15:0] w [3];
  logic [1:0]  n;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      n <= 2'h0;
      w <= '{default: 16'h0000};
    end
    else if (stack_push)
    begin
      w[n] <= stack_data;
      n    <= n + 2'h1;
    end
    else if (!busy)
      n <= 2'h0;
  // second word of a frame is the saved segment, or the flags in a compatible-mode interrupt frame
  assign pop_seg = w[1][5:0];
endmodule

/* verif/rpmsu_top_asserts.sv */
// concurrent checks on the unit's ports
`timescale 1ns/1ps
module rpmsu_top_asserts
  import rpmsu_pkg::*;
(
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        pslverr,
  // register translation
  input logic [3:0]  wreg_idx,
  input logic [7:0]  reg_addr,
  input logic        reg_paged,
  // memory translation
  input logic        mem_req,
  input rpmsu_kind_t mem_kind,
  input logic [15:0] mem_laddr,
  input logic [21:0] mem_phys,
  input logic        mem_valid,
  // sequencer
  input logic        far_call,
  input logic        irq_enter,
  input logic [15:0] cur_pc,
  input logic [15:0] tgt_pc,
  input logic        stack_push,
  input logic [15:0] stack_data,
  input logic        pc_load,
  input logic [15:0] pc_value,
  input logic        busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  mem_valid_a: assert property (mem_req |=> mem_valid)
    else $error("mem_valid missing");
  seg_offset_a: assert property (mem_req && mem_kind != RPMSU_DATA |=>
    mem_phys[15:0] == $past(mem_laddr))
    else $error("segment offset wrong");
  page_offset_a: assert property (mem_req |=> mem_phys[13:0] == $past(mem_laddr[13:0]))
    else $error("page offset wrong");
  reg_index_a: assert property ($past(presetn) |-> reg_addr[2:0] == $past(wreg_idx[2:0]))
    else $error("register index wrong");
  paged_flag_a: assert property (reg_paged == (reg_addr[7:4] == 4'hF))
    else $error("paged flag wrong");
  far_call_a: assert property (far_call && !busy |=> busy ##1
    (stack_push && stack_data == $past(cur_pc, 2)) ##1 stack_push ##1
    (pc_load && pc_value == $past(tgt_pc, 4)))
    else $error("far call sequence wrong");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:4] !busy)
    else $error("branch overhead too long");
  irq_push_a: assert property (irq_enter && !far_call && !busy |->
    ##2 stack_push && stack_data == $past(cur_pc, 2))
    else $error("interrupt entry push wrong");
endmodule
bind rpmsu_top rpmsu_top_asserts u_chk (.*);

/* verif/tb_rpmsu_top.sv */
// self-checking bench for the register pointer and memory segment unit
`timescale 1ns/1ps
module tb_rpmsu_top;
  import rpmsu_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_req = 0, e;
  logic        far_call = 0, far_ret = 0, irq_enter = 0, irq_ret = 0;
  logic        pready, pslverr, reg_paged, mem_valid, stack_push, pc_load, busy;
  logic [7:0]  paddr = 8'h00, reg_addr, cur_flags = 8'hA5;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  wreg_idx = 4'h0;
  logic [5:0]  reg_page, pop_seg, tgt_seg = 6'h05;
  logic [15:0] mem_laddr = 16'h0, cur_pc = 16'h1234, tgt_pc = 16'h0050, stack_data, pc_value;
  logic [21:0] mem_phys;
  rpmsu_kind_t mem_kind = RPMSU_FETCH;
  int          num_errors = 0, n_compared = 0;
  always #12.5 pclk = ~pclk;
  rpmsu_top i_dut (.*);
  rpmsu_core_model i_core (.*);
  task automatic final_report;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      num_errors++;
      $display("FAIL %0t bus access timed out", $time);
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wreg(input logic [3:0] i, input logic [14:0] exp);
    @(posedge pclk);
    wreg_idx <= i;
    @(posedge pclk);
    #1 chk({reg_paged, reg_page, reg_addr}, exp);
  endtask
  task automatic mem(input rpmsu_kind_t k, input logic [15:0] a, input logic [21:0] exp);
    @(posedge pclk);
    mem_req <= 1'b1;
    mem_kind <= k;
    mem_laddr <= a;
    @(posedge pclk);
    mem_req <= 1'b0;
    #1 chk({mem_valid, mem_phys}, {1'b1, exp});
  endtask
  task automatic seq(input logic [3:0] ev);
    int i;
    @(posedge pclk);
    {far_call, far_ret, irq_enter, irq_ret} <= ev;
    @(posedge pclk);
    {far_call, far_ret, irq_enter, irq_ret} <= 4'h0;
    for (i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      if (busy === 1'b0)
        break;
    end
    if (i == 10)
    begin
      num_errors++;
      $display("FAIL %0t sequencer stayed busy", $time);
      final_report();
    end
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 9; a++)
      rd(8'(4 * a), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, RPMSU_OFS_LBP, 32'h02);
    apb(1'b1, RPMSU_OFS_HBP, 32'h1B);
    apb(1'b1, RPMSU_OFS_CTRL, 32'h01);
    rd(RPMSU_OFS_HBP, 32'h1B);
    wreg(4'h0, 15'h10);
    wreg(4'h7, 15'h17);
    wreg(4'hF, 15'hDF);
    apb(1'b1, RPMSU_OFS_CTRL, 32'h00);
    apb(1'b1, RPMSU_OFS_LBP, 32'h03);
    wreg(4'h3, 15'h13);
    apb(1'b1, RPMSU_OFS_PPR, 32'h15);
    rd(RPMSU_OFS_PPR, 32'h15);
    apb(1'b1, RPMSU_OFS_LBP, 32'h1E);
    wreg(4'h5, {1'b1, 6'h15, 8'hF5});
    apb(1'b1, RPMSU_OFS_CSR, 32'h2A);
    apb(1'b1, RPMSU_OFS_ISR, 32'h15);
    apb(1'b1, RPMSU_OFS_DMAS, 32'h3F);
    apb(1'b1, RPMSU_OFS_DPR, 32'h0B07_0220);
    mem(RPMSU_FETCH, 16'hFFFF, {6'h2A, 16'hFFFF});
    mem(RPMSU_DATA, 16'h25A5, 22'h0825A5);
    mem(RPMSU_DATA, 16'h4000, 22'h008000);
    mem(RPMSU_DATA, 16'hBFFF, {8'h07, 14'h3FFF});
    mem(RPMSU_DATA, 16'hC001, {8'h0B, 14'h0001});
    mem(RPMSU_DMA, 16'h0100, {6'h15, 16'h0100});
    apb(1'b1, RPMSU_OFS_CTRL, 32'h04);
    mem(RPMSU_DMA, 16'h0100, {6'h3F, 16'h0100});
    mem(RPMSU_VECTOR, 16'h0008, {6'h15, 16'h0008});
    seq(4'h8);
    chk(i_core.w[0], 16'h1234);
    chk(i_core.w[1], 16'h002A);
    chk(pc_value, 16'h0050);
    rd(RPMSU_OFS_CSR, 32'h05);
    mem(RPMSU_FETCH, 16'h0050, {6'h05, 16'h0050});
    seq(4'h4);
    rd(RPMSU_OFS_CSR, 32'h2A);
    seq(4'h2);
    chk(i_core.w[1], 16'h00A5);
    rd(RPMSU_OFS_STAT, 32'h01);
    rd(RPMSU_OFS_CSR, 32'h2A);
    mem(RPMSU_FETCH, 16'h0010, {6'h15, 16'h0010});
    seq(4'h1);
    mem(RPMSU_FETCH, 16'h0010, {6'h2A, 16'h0010});
    apb(1'b1, RPMSU_OFS_CTRL, 32'h02);
    seq(4'h2);
    chk(i_core.w[1], 16'h002A);
    chk(i_core.w[2], 16'h00A5);
    rd(RPMSU_OFS_CSR, 32'h15);
    seq(4'h1);
    rd(RPMSU_OFS_CSR, 32'h2A);
    final_report();
  end
endmodule
